// ### rtl/dhp_pkg.sv
/*
 Shared constants and types of the display host port: mode codes, two-wire
 address, host register map, field positions, reset values, timing counts.
 Assumes it is compiled before every other file of the block.
*/
// Behaviour
// - Two straps pick one of four protocols
// - Low reset pin initialises; host holds high
// - Device answers only while chip select low
// - Parallel byte with select high is data
// - Select low sends byte to command register
// - Four-wire serial bits with select high are data
// - Two-wire: select pin is address low bit
// - Enable mode: access starts on enable high
// - Enable mode: direction high reads, low writes
// - Separate strobes: read starts on read low
// - Separate strobes: write starts on write low
// - Serial modes: both strobes tied low
// - Four-wire: lines 2,1 data, 0 clock
// - Two-wire: lines 2,1 data, 0 clock
// - Data lines two-way; unused lines tied low
// - Device drives frame sync output
package dhp_pkg;
    typedef logic [1:0] dhp_mode_t;
    // Strap codes as {proto_select_a, proto_select_b}
    localparam dhp_mode_t DHP_MODE_TWI = 2'h2;
    localparam dhp_mode_t DHP_MODE_SPI = 2'h0;
    localparam dhp_mode_t DHP_MODE_SEP = 2'h3;
    localparam dhp_mode_t DHP_MODE_ENA = 2'h1;
    // Fixed upper six bits of the two-wire slave address
    localparam logic [5:0] DHP_TWI_ADDR_HI = 6'h1e;
    localparam int DHP_TWI_CTRL_DC = 6;
    localparam int DHP_SPI_BITS = 8;
    localparam int DHP_TWI_BITS = 27;
    // Every host pin phase lasts this long
    localparam int DHP_SYS_NS = 100;
    localparam int DHP_PHASE_NS = 1600;
    localparam int DHP_PHASE_CYC = (DHP_PHASE_NS + DHP_SYS_NS - 1) / DHP_SYS_NS;
    // Frame sync period and high time, link clock cycles
    localparam int DHP_FRAME_LEN = 256;
    localparam int DHP_FRAME_HIGH = 16;
    // Host register offsets
    localparam logic [1:0] DHP_REG_CFG = 2'h0;
    localparam logic [1:0] DHP_REG_TX = 2'h1;
    localparam logic [1:0] DHP_REG_STAT = 2'h2;
    localparam int DHP_CFG_RST_BIT = 2;
    localparam int DHP_CFG_SA0_BIT = 3;
    localparam int DHP_TX_DC_BIT = 8;
    localparam int DHP_TX_RD_BIT = 9;
    localparam int DHP_STAT_FRAME_BIT = 1;
    localparam int DHP_STAT_NACK_BIT = 2;
    localparam logic [3:0] DHP_CFG_RESET = 4'h7;
    typedef enum logic [2:0] {
        DHP_H_IDLE = 3'h0, DHP_H_SETUP = 3'h1, DHP_H_STROBE = 3'h3,
        DHP_H_RELEASE = 3'h2, DHP_H_END = 3'h6, DHP_H_BITLO = 3'h7,
        DHP_H_BITHI = 3'h5
    } dhp_hstate_t;
    typedef enum logic [2:0] {
        DHP_T_IDLE = 3'h0, DHP_T_ADDR = 3'h1, DHP_T_CTRL = 3'h3,
        DHP_T_DATA = 3'h2, DHP_T_SKIP = 3'h6
    } dhp_tstate_t;
endpackage

// ### rtl/dhp_link_if.sv
/*
 Pins between host and display port. Resolves the shared data lines.
 Assumes each end drives only with its enable high; undriven lines pull high.
*/
`timescale 1ns/1ps
interface dhp_link_if;
    logic proto_select_a, proto_select_b, chip_reset_n, cs_n, dc, en_rd, rw_wr;
    logic [7:0] host_data_o, host_data_oe, dev_data_o, dev_data_oe;
    logic [7:0] host_data_bus, wired;
    logic frame_sync_out;

    // Wired-and with pull-up, so open-drain serial data works
    assign wired = (host_data_o | ~host_data_oe) & (dev_data_o | ~dev_data_oe);
    assign host_data_bus[7:3] = wired[7:3];
    assign host_data_bus[0] = wired[0];
    // Lines 2 and 1 are joined in both serial modes
    assign host_data_bus[2:1] = proto_select_b ? wired[2:1] : {2{&wired[2:1]}};

    modport host (output proto_select_a, proto_select_b, chip_reset_n, cs_n, dc,
                  output en_rd, rw_wr, host_data_o, host_data_oe,
                  input host_data_bus, frame_sync_out);
    modport dev (input proto_select_a, proto_select_b, chip_reset_n, cs_n, dc,
                 input en_rd, rw_wr, host_data_bus,
                 output dev_data_o, dev_data_oe, frame_sync_out);
endinterface

// ### rtl/dhp_sync.sv
/*
 Two-flop synchroniser for a vector of independent levels.
 Assumes each bit is a level that is stable for several destination cycles.
*/
`timescale 1ns/1ps
module dhp_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge i_clk) begin
        meta_reg <= i_d;
        o_q <= meta_reg;
    end
endmodule

// ### rtl/dhp_dev.sv
/*
 Display end of the host port, clocked by the link clock. Decodes the straps,
 chip select, data/command and strobes, and delivers bytes to data or command.
 Assumes the host holds every pin level for several link clock cycles.
*/
`timescale 1ns/1ps
module dhp_dev (
    dhp_link_if.dev link,
    input wire logic i_link_clk,
    input wire logic i_link_rst,
    input wire logic [7:0] i_read_byte,
    output dhp_pkg::dhp_mode_t o_mode,
    output logic [7:0] o_data_byte,
    output logic o_data_valid,
    output logic [7:0] o_cmd_reg,
    output logic o_cmd_valid
);
    import dhp_pkg::*;

    logic [14:0] pin_raw;
    logic [14:0] pin_s;
    dhp_mode_t s_mode;
    logic s_rst_n, s_cs_n, s_dc, s_er, s_rw;
    logic [7:0] s_bus;
    logic ctl_rst, sel, is_sep, is_ena, is_spi, is_twi;
    logic prev_er_reg, prev_rw_reg, prev_c_reg, prev_d_reg;
    logic sdi, clk_rise, clk_fall, tw_start, tw_stop, byte_rise;
    logic [7:0] full_byte;
    logic [6:0] sh_reg;
    logic [3:0] bitcnt_reg;
    dhp_tstate_t tstate_reg, tstate_next;
    logic ack_pend_reg, ack_drv_reg, twi_dc_reg, addr_match, twi_ack;
    logic sep_wr, ena_wr, spi_done, twi_emit, emit, emit_dc;
    logic [7:0] emit_byte;
    logic sep_rd, ena_rd, rd_start, rd_act;
    logic [7:0] dev_o_reg, dev_oe_reg;
    logic [7:0] frame_cnt_reg;
    logic frame_reg;

    function automatic logic mode_is(input dhp_mode_t m, input dhp_mode_t want);
        mode_is = (m == want);
    endfunction

    // All pins cross into the link domain
    assign pin_raw = {link.proto_select_a, link.proto_select_b, link.chip_reset_n,
                      link.cs_n, link.dc, link.en_rd, link.rw_wr, link.host_data_bus};

    dhp_sync #(.W(15)) u_pin_sync (
        .i_clk(i_link_clk),
        .i_d(pin_raw),
        .o_q(pin_s)
    );

    assign s_mode = pin_s[14:13];
    assign s_rst_n = pin_s[12];
    assign s_cs_n = pin_s[11];
    assign s_dc = pin_s[10];
    assign s_er = pin_s[9];
    assign s_rw = pin_s[8];
    assign s_bus = pin_s[7:0];

    // Straps decoded every cycle, never latched
    assign is_twi = mode_is(s_mode, DHP_MODE_TWI);
    assign is_spi = mode_is(s_mode, DHP_MODE_SPI);
    assign is_sep = mode_is(s_mode, DHP_MODE_SEP);
    assign is_ena = mode_is(s_mode, DHP_MODE_ENA);

    // Reset pin low holds the whole controller in reset
    assign ctl_rst = i_link_rst | ~s_rst_n;
    assign sel = ~s_cs_n;

    // Serial clock on line 0, serial data on lines 2 and 1
    assign sdi = s_bus[1];
    assign clk_rise = ~prev_c_reg & s_bus[0];
    assign clk_fall = prev_c_reg & ~s_bus[0];
    assign tw_start = s_bus[0] & prev_c_reg & prev_d_reg & ~sdi;
    assign tw_stop = s_bus[0] & prev_c_reg & ~prev_d_reg & sdi;
    assign byte_rise = clk_rise & (bitcnt_reg == 4'h7);
    assign full_byte = {sh_reg, sdi};

    // Two-wire address: fixed upper bits, low bit from the select pin
    assign addr_match = (full_byte[7:1] == {DHP_TWI_ADDR_HI, s_dc}) & ~full_byte[0];

    // Next byte phase of a two-wire write
    always_comb begin
        tstate_next = tstate_reg;
        unique case (tstate_reg)
            DHP_T_ADDR: tstate_next = addr_match ? DHP_T_CTRL : DHP_T_SKIP;
            DHP_T_CTRL: tstate_next = DHP_T_DATA;
            DHP_T_DATA: tstate_next = DHP_T_DATA;
            DHP_T_IDLE: tstate_next = DHP_T_IDLE;
            DHP_T_SKIP: tstate_next = DHP_T_SKIP;
            default: tstate_next = DHP_T_IDLE;
        endcase
    end

    assign twi_ack = (tstate_reg == DHP_T_ADDR) ? addr_match :
                     (tstate_reg == DHP_T_CTRL) | (tstate_reg == DHP_T_DATA);

    // Byte delivery from whichever protocol is active
    assign sep_wr = is_sep & sel & prev_rw_reg & ~s_rw;
    assign ena_wr = is_ena & sel & ~prev_er_reg & s_er & ~s_rw;
    assign spi_done = is_spi & sel & byte_rise;
    assign twi_emit = is_twi & sel & byte_rise & (tstate_reg == DHP_T_DATA);
    assign emit = sep_wr | ena_wr | spi_done | twi_emit;
    assign emit_byte = (is_sep | is_ena) ? s_bus : full_byte;
    // Two-wire takes data/command from its control byte
    assign emit_dc = is_twi ? twi_dc_reg : s_dc;

    // Reads: separate read strobe low, or enable high with direction high
    assign sep_rd = is_sep & sel & prev_er_reg & ~s_er;
    assign ena_rd = is_ena & sel & ~prev_er_reg & s_er & s_rw;
    assign rd_start = sep_rd | ena_rd;
    assign rd_act = sel & ((is_sep & ~s_er) | (is_ena & s_er & s_rw));

    // Edge history of strobes and serial lines
    always_ff @(posedge i_link_clk) begin
        if (ctl_rst) begin
            prev_er_reg <= 1'b0;
            prev_rw_reg <= 1'b0;
            prev_c_reg <= 1'b0;
            prev_d_reg <= 1'b0;
        end else begin
            prev_er_reg <= s_er;
            prev_rw_reg <= s_rw;
            prev_c_reg <= s_bus[0];
            prev_d_reg <= sdi;
        end
    end

    // Serial shifter; a deselected chip drops any half byte
    always_ff @(posedge i_link_clk) begin
        if (ctl_rst | ~sel) begin
            sh_reg <= 7'h00;
            bitcnt_reg <= 4'h0;
            tstate_reg <= DHP_T_IDLE;
            ack_pend_reg <= 1'b0;
            ack_drv_reg <= 1'b0;
            twi_dc_reg <= 1'b0;
        end else if (is_spi) begin
            if (clk_rise) begin
                sh_reg <= full_byte[6:0];
                bitcnt_reg <= byte_rise ? 4'h0 : bitcnt_reg + 4'h1;
            end
        end else if (is_twi) begin
            if (tw_start) begin
                tstate_reg <= DHP_T_ADDR;
                bitcnt_reg <= 4'h0;
                ack_drv_reg <= 1'b0;
            end else if (tw_stop) begin
                tstate_reg <= DHP_T_IDLE;
                ack_drv_reg <= 1'b0;
            end else begin
                if (clk_rise) begin
                    sh_reg <= full_byte[6:0];
                    bitcnt_reg <= (bitcnt_reg == 4'h8) ? 4'h0 : bitcnt_reg + 4'h1;
                end
                if (byte_rise) begin
                    tstate_reg <= tstate_next;
                    ack_pend_reg <= twi_ack;
                end
                if (byte_rise & (tstate_reg == DHP_T_CTRL)) begin
                    twi_dc_reg <= full_byte[DHP_TWI_CTRL_DC];
                end
                // Hold data low for the ninth clock only
                if (clk_fall) begin
                    ack_drv_reg <= (bitcnt_reg == 4'h8) & ack_pend_reg;
                end
            end
        end
    end

    // Data and command outputs; command byte is also kept
    always_ff @(posedge i_link_clk) begin
        if (ctl_rst) begin
            o_data_byte <= 8'h00;
            o_data_valid <= 1'b0;
            o_cmd_reg <= 8'h00;
            o_cmd_valid <= 1'b0;
            o_mode <= DHP_MODE_SPI;
        end else begin
            o_mode <= s_mode;
            o_data_valid <= emit & emit_dc;
            o_cmd_valid <= emit & ~emit_dc;
            if (emit & emit_dc) begin
                o_data_byte <= emit_byte;
            end
            if (emit & ~emit_dc) begin
                o_cmd_reg <= emit_byte;
            end
        end
    end

    // Bus drive: read byte is frozen at the start of the read
    always_ff @(posedge i_link_clk) begin
        if (ctl_rst) begin
            dev_o_reg <= 8'h00;
            dev_oe_reg <= 8'h00;
        end else begin
            if (rd_start) begin
                dev_o_reg <= i_read_byte;
            end else if (~rd_act) begin
                dev_o_reg <= 8'h00;
            end
            // Ack pulls line 2 low, which is joined to line 1
            dev_oe_reg <= rd_act ? 8'hff : {5'h00, ack_drv_reg & is_twi, 2'h0};
        end
    end

    assign link.dev_data_o = dev_o_reg;
    assign link.dev_data_oe = dev_oe_reg;

    // Frame sync free-runs, so the host can time its writes
    always_ff @(posedge i_link_clk) begin
        if (ctl_rst) begin
            frame_cnt_reg <= 8'h00;
            frame_reg <= 1'b0;
        end else begin
            frame_cnt_reg <= (frame_cnt_reg == 8'(DHP_FRAME_LEN - 1)) ? 8'h00
                             : frame_cnt_reg + 8'h01;
            frame_reg <= frame_cnt_reg < 8'(DHP_FRAME_HIGH);
        end
    end

    assign link.frame_sync_out = frame_reg;
endmodule

// ### rtl/dhp_host.sv
/*
 Host end of the display port on the system clock. Software sets the mode
 and chip reset, then queues bytes or reads through a small register port.
 Assumes the display end samples every pin level within one phase.
*/
`timescale 1ns/1ps
module dhp_host (
    dhp_link_if.host link,
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata
);
    import dhp_pkg::*;

    logic [8:0] in_s;
    logic [3:0] cfg_reg;
    dhp_mode_t mode;
    logic par, twi, spi, tick, last_bit, go;
    dhp_hstate_t st_reg, st_next;
    logic [4:0] tmr_reg, bit_reg;
    logic [26:0] sh_reg;
    logic [7:0] byte_reg, rdbyte_reg;
    logic dc_reg, rdreq_reg, nack_reg, sbit, idle, act, sda_low, scl;
    logic cs_n_w, er_w, rw_w;
    logic [7:0] o_w, oe_w, o_reg, oe_reg;
    logic cs_n_reg, er_reg, rw_reg, dc_pin_reg;
    logic [1:0] strap_reg;

    dhp_sync #(.W(9)) u_in_sync (
        .i_clk(i_sys_clk),
        .i_d({link.frame_sync_out, link.host_data_bus}),
        .o_q(in_s)
    );

    assign mode = cfg_reg[1:0];
    assign par = mode[0];
    assign twi = (mode == DHP_MODE_TWI);
    assign spi = (mode == DHP_MODE_SPI);
    assign idle = (st_reg == DHP_H_IDLE);
    assign act = (st_reg == DHP_H_STROBE);
    assign sbit = sh_reg[26];
    assign tick = (tmr_reg == 5'(DHP_PHASE_CYC - 1));
    assign last_bit = bit_reg == (twi ? 5'(DHP_TWI_BITS - 1) : 5'(DHP_SPI_BITS - 1));
    // A queued byte while busy is dropped
    assign go = i_wr & (i_addr == DHP_REG_TX) & idle;

    // Phase sequencer
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            DHP_H_IDLE: st_next = go ? DHP_H_SETUP : DHP_H_IDLE;
            DHP_H_SETUP: st_next = par ? DHP_H_STROBE : DHP_H_BITLO;
            DHP_H_STROBE: st_next = DHP_H_RELEASE;
            DHP_H_RELEASE: st_next = par ? DHP_H_END : DHP_H_IDLE;
            DHP_H_BITLO: st_next = DHP_H_BITHI;
            DHP_H_BITHI: st_next = last_bit ? DHP_H_END : DHP_H_BITLO;
            DHP_H_END: st_next = par ? DHP_H_IDLE : DHP_H_RELEASE;
            default: st_next = DHP_H_IDLE;
        endcase
    end

    // Pin levels for each phase
    assign cs_n_w = idle | (par & st_reg == DHP_H_END) | (spi & st_reg == DHP_H_RELEASE);
    assign er_w = !par ? 1'b0 : mode[1] ? ~(act & rdreq_reg) : act;
    assign rw_w = !par ? 1'b0 : mode[1] ? ~(act & ~rdreq_reg) : rdreq_reg & ~idle;
    assign scl = ~((st_reg == DHP_H_BITLO) | (st_reg == DHP_H_END));
    assign sda_low = (st_reg == DHP_H_SETUP) | (st_reg == DHP_H_END) |
                     (st_reg == DHP_H_RELEASE) |
                     (((st_reg == DHP_H_BITLO) | (st_reg == DHP_H_BITHI)) & ~sbit);
    // Unused lines driven low in serial modes
    assign o_w = par ? byte_reg : twi ? {7'h00, scl} : {5'h00, sbit, sbit, st_reg == DHP_H_BITHI};
    assign oe_w = par ? {8{~idle & ~rdreq_reg}} : twi ? {5'h1f, sda_low, sda_low, 1'b1} : 8'hff;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cfg_reg <= DHP_CFG_RESET;
            st_reg <= DHP_H_IDLE;
            tmr_reg <= 5'h00;
            bit_reg <= 5'h00;
            sh_reg <= 27'h0;
            byte_reg <= 8'h00;
            dc_reg <= 1'b0;
            rdreq_reg <= 1'b0;
            rdbyte_reg <= 8'h00;
            nack_reg <= 1'b0;
        end else begin
            // Mode moves only with a write that holds chip reset asserted
            if (i_wr & (i_addr == DHP_REG_CFG)) begin
                cfg_reg[3:2] <= i_wdata[3:2];
                if (i_wdata[DHP_CFG_RST_BIT]) begin
                    cfg_reg[1:0] <= i_wdata[1:0];
                end
            end
            tmr_reg <= (idle | tick) ? 5'h00 : tmr_reg + 5'h01;
            if (go) begin
                st_reg <= st_next;
                byte_reg <= i_wdata[7:0];
                dc_reg <= i_wdata[DHP_TX_DC_BIT];
                rdreq_reg <= i_wdata[DHP_TX_RD_BIT] & par;
                bit_reg <= 5'h00;
                sh_reg <= twi ? {DHP_TWI_ADDR_HI, cfg_reg[DHP_CFG_SA0_BIT], 2'h1, 1'b0,
                                 i_wdata[DHP_TX_DC_BIT], 6'h00, 1'b1, i_wdata[7:0], 1'b1}
                              : {i_wdata[7:0], 19'h0};
            end else if (tick & ~idle) begin
                st_reg <= st_next;
                if (act & rdreq_reg) begin
                    rdbyte_reg <= in_s[7:0];
                end
                if (st_reg == DHP_H_BITHI) begin
                    sh_reg <= {sh_reg[25:0], 1'b1};
                    bit_reg <= bit_reg + 5'h01;
                    if (twi & (bit_reg == 5'h08)) begin
                        nack_reg <= in_s[1];
                    end
                end
            end
        end
    end

    // Pins registered; the interface sees only flops
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cs_n_reg <= 1'b1;
            er_reg <= 1'b0;
            rw_reg <= 1'b0;
            dc_pin_reg <= 1'b0;
            o_reg <= 8'h00;
            oe_reg <= 8'h00;
            o_rdata <= 16'h0000;
            strap_reg <= DHP_CFG_RESET[1:0];
        end else begin
            // Straps flop beside the strobes, so no strobe outlives its mode
            strap_reg <= cfg_reg[1:0];
            cs_n_reg <= cs_n_w;
            er_reg <= er_w;
            rw_reg <= rw_w;
            dc_pin_reg <= twi ? cfg_reg[DHP_CFG_SA0_BIT] : dc_reg;
            o_reg <= o_w;
            oe_reg <= oe_w;
            o_rdata <= 16'h0000;
            if (i_rd & (i_addr == DHP_REG_CFG)) begin
                o_rdata <= {12'h000, cfg_reg};
            end
            if (i_rd & (i_addr == DHP_REG_STAT)) begin
                o_rdata <= {rdbyte_reg, 5'h00, nack_reg, in_s[8], ~idle};
            end
        end
    end

    assign link.proto_select_a = strap_reg[1];
    assign link.proto_select_b = strap_reg[0];
    assign link.chip_reset_n = ~cfg_reg[DHP_CFG_RST_BIT];
    assign link.cs_n = cs_n_reg;
    assign link.dc = dc_pin_reg;
    assign link.en_rd = er_reg;
    assign link.rw_wr = rw_reg;
    assign link.host_data_o = o_reg;
    assign link.host_data_oe = oe_reg;
endmodule

// ### testbench/dhp_props.sv
/*
 Concurrent checks on the pins between the host end and the display end.
 Assumes it is instantiated beside the link interface, every pin by name.
*/
`timescale 1ns/1ps
module dhp_props (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_link_clk,
    input wire logic i_link_rst,
    input wire logic proto_select_a,
    input wire logic proto_select_b,
    input wire logic chip_reset_n,
    input wire logic cs_n,
    input wire logic en_rd,
    input wire logic rw_wr,
    input wire logic [7:0] dev_data_oe,
    input wire logic frame_sync_out
);
    // Device logic sleeps while either reset source is active
    wire off = i_link_rst | ~chip_reset_n;
    wire sep = proto_select_a & proto_select_b;
    wire ena = ~proto_select_a & proto_select_b;
    wire four = ~proto_select_a & ~proto_select_b;
    wire two = proto_select_a & ~proto_select_b;
    // Six link cycles cover the pin synchroniser plus the output flop
    sequence s_sep_rd;
        (sep && !cs_n && !en_rd && rw_wr) [*6];
    endsequence
    sequence s_ena_rd;
        (ena && !cs_n && en_rd && rw_wr) [*6];
    endsequence
    sequence s_frame_hi;
        frame_sync_out [*8] ##1 frame_sync_out [*8];
    endsequence
    property p_idle;
        @(posedge i_link_clk) disable iff (off) cs_n [*6] |-> dev_data_oe == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("bus driven while deselected");
    property p_sep_rd;
        @(posedge i_link_clk) disable iff (off) s_sep_rd |-> dev_data_oe == 8'hff;
    endproperty
    a_sep_rd: assert property (p_sep_rd) else $error("read strobe not answered");
    property p_ena_rd;
        @(posedge i_link_clk) disable iff (off) s_ena_rd |-> dev_data_oe == 8'hff;
    endproperty
    a_ena_rd: assert property (p_ena_rd) else $error("enable read not answered");
    property p_sep_wr;
        @(posedge i_link_clk) disable iff (off) (sep && en_rd) [*6] |-> dev_data_oe == 8'h00;
    endproperty
    a_sep_wr: assert property (p_sep_wr) else $error("bus driven with no read");
    property p_four_in;
        @(posedge i_link_clk) disable iff (off) four |-> dev_data_oe == 8'h00;
    endproperty
    a_four_in: assert property (p_four_in) else $error("four-wire line driven");
    property p_two_ack;
        @(posedge i_link_clk) disable iff (off) two |-> (dev_data_oe & 8'hfb) == 8'h00;
    endproperty
    a_two_ack: assert property (p_two_ack) else $error("two-wire wrong line driven");
    property p_frame_hi;
        @(posedge i_link_clk) disable iff (off)
            $rose(frame_sync_out) |-> s_frame_hi ##1 !frame_sync_out;
    endproperty
    a_frame_hi: assert property (p_frame_hi) else $error("frame sync width wrong");
    property p_frame_gap;
        @(posedge i_link_clk) disable iff (off)
            $fell(frame_sync_out) |-> ##239 !frame_sync_out ##1 frame_sync_out;
    endproperty
    a_frame_gap: assert property (p_frame_gap) else $error("frame sync period wrong");
    // Host side: the strobes rest low in serial modes, straps stay put
    property p_strobes_low;
        @(posedge i_sys_clk) disable iff (i_sys_rst) !proto_select_b |-> !en_rd && !rw_wr;
    endproperty
    a_strobes_low: assert property (p_strobes_low) else $error("strobe active in serial");
    property p_straps;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
            chip_reset_n && $past(chip_reset_n) |-> $stable({proto_select_a, proto_select_b});
    endproperty
    a_straps: assert property (p_straps) else $error("strap moved out of reset");
endmodule

// ### testbench/display_host_port_decode_tb.sv
/*
 Self-checking bench: host end and display end joined by the link interface.
 Assumes the package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
module display_host_port_decode_tb;
    import dhp_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic link_clk = 1'b0;
    logic link_rst = 1'b1;
    logic [1:0] i_addr = 2'h0;
    logic [15:0] i_wdata = 16'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    logic [7:0] read_byte = 8'h00;
    logic [7:0] data_byte, cmd_reg;
    logic data_valid, cmd_valid;
    dhp_mode_t dev_mode;
    dhp_mode_t modes [5] = '{DHP_MODE_SEP, DHP_MODE_ENA, DHP_MODE_SPI, DHP_MODE_TWI, DHP_MODE_TWI};
    logic [31:0] lfsr = 32'h31db;
    logic [8:0] got_q [$];
    int errors = 0;
    int samples_checked = 0;

    always #50 i_sys_clk = ~i_sys_clk;
    // Link edges rise at 80 + 160k ns, never on a rising system edge
    always #80 link_clk = ~link_clk;

    dhp_link_if link_i ();
    dhp_host dhp_host_i (.link(link_i), .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
    dhp_dev dhp_dev_i (.link(link_i), .i_link_clk(link_clk), .i_link_rst(link_rst),
        .i_read_byte(read_byte), .o_mode(dev_mode), .o_data_byte(data_byte),
        .o_data_valid(data_valid), .o_cmd_reg(cmd_reg), .o_cmd_valid(cmd_valid));
    dhp_props dhp_props_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_link_clk(link_clk), .i_link_rst(link_rst), .proto_select_a(link_i.proto_select_a),
        .proto_select_b(link_i.proto_select_b), .chip_reset_n(link_i.chip_reset_n),
        .cs_n(link_i.cs_n), .en_rd(link_i.en_rd), .rw_wr(link_i.rw_wr),
        .dev_data_oe(link_i.dev_data_oe), .frame_sync_out(link_i.frame_sync_out));

    // Log every delivered byte with its kind: 1 data, 0 command
    always @(posedge link_clk) begin
        if (data_valid === 1'b1) got_q.push_back({1'b1, data_byte});
        if (cmd_valid === 1'b1) got_q.push_back({1'b0, cmd_reg});
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // What the display end should log for one written byte
    function automatic logic [15:0] exp_entry(input logic dc, input logic [7:0] b);
        return {7'h0, dc, b};
    endfunction

    task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Straps move only while the chip reset is held
    task automatic set_mode(input dhp_mode_t m, input logic sa0);
        reg_wr(DHP_REG_CFG, {12'h0, sa0, 1'b1, m});
        repeat (8) @(posedge i_sys_clk);
        chk("mode in reset", 16'h0, {14'h0, dev_mode});
        reg_wr(DHP_REG_CFG, {12'h0, sa0, 1'b0, m});
        // A mode change with the chip running must be refused
        reg_wr(DHP_REG_CFG, {12'h0, sa0, 1'b0, ~m});
        repeat (20) @(posedge i_sys_clk);
        chk("mode", {14'h0, m}, {14'h0, dev_mode});
    endtask

    task automatic xfer(input logic dc, input logic rd, input logic [7:0] b, input logic two);
        logic [15:0] s;
        int n;
        got_q.delete();
        read_byte <= b;
        reg_wr(DHP_REG_TX, {6'h0, rd, dc, b});
        n = 0;
        s = 16'h1;
        while (s[0] !== 1'b0 && n < 3000) begin
            reg_rd(DHP_REG_STAT, s);
            n++;
        end
        chk("busy", 16'h0, {15'h0, s[0]});
        if (two) chk("nack", 16'h0, {15'h0, s[2]});
        if (rd) begin
            chk("read byte", {8'h0, b}, {8'h0, s[15:8]});
            chk("count", 16'h0, 16'(got_q.size()));
        end else begin
            chk("count", 16'h1, 16'(got_q.size()));
            if (got_q.size() != 0) chk("byte", exp_entry(dc, b), {7'h0, got_q[0]});
        end
    endtask

    // Some forty transfers of at most about 1000 cycles each, doubled
    initial begin
        #(80000 * 100);
        errors++;
        print_verdict();
    end

    initial begin
        logic [15:0] d;
        logic par;
        logic two;
        repeat (2) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        link_rst <= 1'b0;
        reg_rd(DHP_REG_CFG, d);
        chk("cfg reset", {12'h0, DHP_CFG_RESET}, d);
        reg_rd(2'h3, d);
        chk("unmapped", 16'h0, d);
        for (int i = 0; i < 5; i++) begin
            par = modes[i][0];
            two = (modes[i] == DHP_MODE_TWI);
            set_mode(modes[i], i == 4);
            xfer(1'b0, 1'b0, 8'h00, two);
            xfer(1'b1, 1'b0, 8'hff, two);
            for (int k = 0; k < 5; k++) begin
                lfsr = lfsr_next(lfsr);
                xfer(lfsr[8] | (par & lfsr[9]), par & lfsr[9], lfsr[7:0], two);
            end
            if (par) xfer(1'b1, 1'b1, 8'h5a, two);
            $display("test mode %0d done", i);
        end
        print_verdict();
    end
endmodule
